//--- shcs_pkg.sv
/*
  Constants and types shared by the system handler control and state block:
  register offset, field positions, writable mask, reset value and the
  identifiers of the exceptions that the core reports.
  Assumes a 32-bit APB register bus and a core on the same clock.
*/
package shcs_pkg;

  // ----------------------------------------------------------------------
  // bus geometry
  // ----------------------------------------------------------------------
  localparam int          APB_ADDR_W  = 12;
  localparam int          DATA_W      = 32;
  localparam int          STRB_W      = DATA_W / 8;
  localparam logic [11:0] SHCS_OFFSET = 12'h000;

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int ACCESS_FAULT_EN_BIT    = 16;
  localparam int SUPERVISOR_PEND_BIT    = 15;
  localparam int BUS_FAULT_PEND_BIT     = 14;
  localparam int ACCESS_FAULT_PEND_BIT  = 13;
  localparam int INSTR_FAULT_PEND_BIT   = 12;
  localparam int TIMER_ACT_BIT          = 11;
  localparam int DEFERRED_ACT_BIT       = 10;
  localparam int DEBUG_ACT_BIT          = 8;
  localparam int SUPERVISOR_ACT_BIT     = 7;
  localparam int INSTR_FAULT_ACT_BIT    = 3;
  localparam int BUS_FAULT_ACT_BIT      = 1;

  // bits 9, 6:4, 2, 0 and 31:17 read zero and ignore writes
  localparam logic [31:0] SHCS_WRITABLE = 32'h0001_fd8a;
  localparam logic [31:0] SHCS_RESET    = 32'h0000_0000;

  // ----------------------------------------------------------------------
  // pending and active vectors
  // ----------------------------------------------------------------------
  localparam int PEND_W = 4;
  localparam int ACT_W  = 6;
  // pending index: 0 supervisor, 1 bus, 2 access, 3 instruction
  localparam int PI_SUPERVISOR = 0;
  localparam int PI_BUS        = 1;
  localparam int PI_ACCESS     = 2;
  localparam int PI_INSTR      = 3;
  // active index: 0 timer, 1 deferred, 2 debug, 3 supervisor, 4 instr, 5 bus
  localparam int AI_TIMER      = 0;
  localparam int AI_DEFERRED   = 1;
  localparam int AI_DEBUG      = 2;
  localparam int AI_SUPERVISOR = 3;
  localparam int AI_INSTR      = 4;
  localparam int AI_BUS        = 5;
  localparam logic [PEND_W-1:0] PEND_RESET = 4'h0;
  localparam logic [ACT_W-1:0]  ACT_RESET  = 6'h00;

  // ----------------------------------------------------------------------
  // exception identifiers reported by the core on take and return
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    EXC_SUPERVISOR = 3'h0,
    EXC_BUS_FAULT  = 3'h1,
    EXC_ACCESS     = 3'h2,
    EXC_INSTR      = 3'h3,
    EXC_TIMER      = 3'h4,
    EXC_DEFERRED   = 3'h5,
    EXC_DEBUG      = 3'h6,
    EXC_OTHER      = 3'h7
  } exc_id_t;

endpackage

//--- status_flags.sv
/*
  A vector of status flags that software writes directly and that the
  core sets and clears by events.
  Assumes all inputs are on the clock's domain.
*/
module status_flags
  import shcs_pkg::*;
#(
  parameter int          W          = 4,
  parameter logic [W-1:0] RESET_VALUE = '0
) (
  // clock and reset
  input  wire logic         clock,
  input  wire logic         rst,
  // software side
  input  wire logic         swWrite,
  input  wire logic [W-1:0] swData,
  // hardware side
  input  wire logic [W-1:0] hwSet,
  input  wire logic [W-1:0] hwClear,
  // state
  output logic      [W-1:0] flags
);

  logic [W-1:0] afterWrite;
  logic [W-1:0] next_flags;

  // software value first, then hardware clear, hardware set wins last
  assign afterWrite = swWrite ? swData : flags;
  assign next_flags = (afterWrite & ~hwClear) | hwSet;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      flags <= RESET_VALUE;
    end else begin
      flags <= next_flags;
    end
  end

endmodule

//--- apb_reg_port.sv
/*
  APB slave front end for a single-word register: decode, privilege check,
  error answer and a registered read data path. No wait states.
  Assumes an APB master on the same clock.
*/
module apb_reg_port
  import shcs_pkg::*;
(
  // clock and reset
  input  wire logic                  clock,
  input  wire logic                  rst,
  // apb
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [APB_ADDR_W-1:0] paddr,
  input  wire logic [2:0]            pprot,
  output logic      [DATA_W-1:0]     prdata,
  output logic                       pready,
  output logic                       pslverr,
  // register side
  input  wire logic [DATA_W-1:0]     readValue,
  output logic                       regWrite
);

  logic hit;
  logic privileged;
  logic setup;
  logic access;
  logic allowed;

  assign hit        = paddr == SHCS_OFFSET;
  assign privileged = pprot[0];
  assign setup      = psel & ~penable;
  assign access     = psel & penable;
  assign allowed    = hit & privileged;
  assign pready     = access;
  assign pslverr    = access & ~allowed;
  assign regWrite   = access & allowed & pwrite;

  // read value is captured in the setup cycle
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (setup) begin
      prdata <= (allowed && !pwrite) ? readValue : 32'h0000_0000;
    end
  end

endmodule

//--- system_handler_control_state.sv
/*
  System handler control and state register: the access protection fault
  enable, the pending bits of four exceptions and the active bits of six.
  Software reaches it over APB; the core reports faults, exception entry
  and exception return on the same clock and reads back the state.
  Assumes the enables of the bus and instruction faults are held elsewhere
  and arrive as levels.
*/
// Added by the designer: the register offset and the APB register port.

module system_handler_control_state
  import shcs_pkg::*;
(
  // clock and reset
  input  wire logic                  clock,
  input  wire logic                  rst,
  // apb register bus
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [APB_ADDR_W-1:0] paddr,
  input  wire logic [DATA_W-1:0]     pwdata,
  input  wire logic [STRB_W-1:0]     pstrb,
  input  wire logic [2:0]            pprot,
  output logic      [DATA_W-1:0]     prdata,
  output logic                       pready,
  output logic                       pslverr,
  // fault and call requests from the core
  input  wire logic                  supervisorCallRequest,
  input  wire logic                  busFaultRequest,
  input  wire logic                  accessFaultRequest,
  input  wire logic                  instructionFaultRequest,
  // enables held outside this register
  input  wire logic                  busFaultEnable,
  input  wire logic                  instructionFaultEnable,
  // exception entry and return
  input  wire logic                  takeValid,
  input  wire exc_id_t               takeId,
  input  wire logic                  returnValid,
  input  wire exc_id_t               returnId,
  // state seen by the core
  output logic                       accessFaultEnable,
  output logic      [PEND_W-1:0]     pendingVector,
  output logic      [ACT_W-1:0]      activeVector,
  output logic                       hardFaultRequest
);

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------

  // one-hot pending index of a pendable exception, zero for the others
  function automatic logic [PEND_W-1:0] pendMask(input exc_id_t id);
    logic [PEND_W-1:0] m;
    m = '0;
    unique case (id)
      EXC_SUPERVISOR: m[PI_SUPERVISOR] = 1'b1;
      EXC_BUS_FAULT:  m[PI_BUS]        = 1'b1;
      EXC_ACCESS:     m[PI_ACCESS]     = 1'b1;
      EXC_INSTR:      m[PI_INSTR]      = 1'b1;
      default:        m = '0;
    endcase
    return m;
  endfunction

  // one-hot active index of an exception that has an active bit here
  function automatic logic [ACT_W-1:0] actMask(input exc_id_t id);
    logic [ACT_W-1:0] m;
    m = '0;
    unique case (id)
      EXC_TIMER:      m[AI_TIMER]      = 1'b1;
      EXC_DEFERRED:   m[AI_DEFERRED]   = 1'b1;
      EXC_DEBUG:      m[AI_DEBUG]      = 1'b1;
      EXC_SUPERVISOR: m[AI_SUPERVISOR] = 1'b1;
      EXC_INSTR:      m[AI_INSTR]      = 1'b1;
      EXC_BUS_FAULT:  m[AI_BUS]        = 1'b1;
      default:        m = '0;
    endcase
    return m;
  endfunction

  // byte lanes of a write turned into a bit mask
  function automatic logic [DATA_W-1:0] laneMask(input logic [STRB_W-1:0] strb);
    logic [DATA_W-1:0] m;
    m = '0;
    for (int i = 0; i < STRB_W; i++) begin
      m[i*8 +: 8] = {8{strb[i]}};
    end
    return m;
  endfunction

  // ----------------------------------------------------------------------
  // bus front end
  // ----------------------------------------------------------------------

  logic              regWrite;
  logic [DATA_W-1:0] readValue;

  apb_reg_port u_port (
    .clock     (clock),
    .rst       (rst),
    .psel      (psel),
    .penable   (penable),
    .pwrite    (pwrite),
    .paddr     (paddr),
    .pprot     (pprot),
    .prdata    (prdata),
    .pready    (pready),
    .pslverr   (pslverr),
    .readValue (readValue),
    .regWrite  (regWrite)
  );

  // ----------------------------------------------------------------------
  // write value
  // ----------------------------------------------------------------------

  logic [DATA_W-1:0] byteMask;
  logic [DATA_W-1:0] writeMask;
  logic [DATA_W-1:0] merged;

  // untouched lanes keep the current value; reserved bits never stored
  assign byteMask  = laneMask(pstrb);
  assign writeMask = byteMask & SHCS_WRITABLE;
  assign merged    = (readValue & ~writeMask) | (pwdata & writeMask);

  // ----------------------------------------------------------------------
  // enable
  // ----------------------------------------------------------------------

  logic next_accessFaultEnable;

  assign next_accessFaultEnable = regWrite ? merged[ACCESS_FAULT_EN_BIT] : accessFaultEnable;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      accessFaultEnable <= SHCS_RESET[ACCESS_FAULT_EN_BIT];
    end else begin
      accessFaultEnable <= next_accessFaultEnable;
    end
  end

  // ----------------------------------------------------------------------
  // fault routing
  // ----------------------------------------------------------------------

  logic busEscalate;
  logic accessEscalate;
  logic instrEscalate;
  logic next_hardFaultRequest;

  // a fault whose handler is disabled becomes a hard fault, not pending
  assign busEscalate    = busFaultRequest & ~busFaultEnable;
  assign accessEscalate = accessFaultRequest & ~accessFaultEnable;
  assign instrEscalate  = instructionFaultRequest & ~instructionFaultEnable;
  assign next_hardFaultRequest = busEscalate | accessEscalate | instrEscalate;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      hardFaultRequest <= 1'b0;
    end else begin
      hardFaultRequest <= next_hardFaultRequest;
    end
  end

  // ----------------------------------------------------------------------
  // pending bits
  // ----------------------------------------------------------------------

  logic [PEND_W-1:0] pendWrite;
  logic [PEND_W-1:0] pendSet;
  logic [PEND_W-1:0] pendClear;

  assign pendWrite[PI_SUPERVISOR] = merged[SUPERVISOR_PEND_BIT];
  assign pendWrite[PI_BUS]        = merged[BUS_FAULT_PEND_BIT];
  assign pendWrite[PI_ACCESS]     = merged[ACCESS_FAULT_PEND_BIT];
  assign pendWrite[PI_INSTR]      = merged[INSTR_FAULT_PEND_BIT];

  assign pendSet[PI_SUPERVISOR] = supervisorCallRequest;
  assign pendSet[PI_BUS]        = busFaultRequest & busFaultEnable;
  assign pendSet[PI_ACCESS]     = accessFaultRequest & accessFaultEnable;
  assign pendSet[PI_INSTR]      = instructionFaultRequest & instructionFaultEnable;

  assign pendClear = takeValid ? pendMask(takeId) : '0;

  status_flags #(
    .W           (PEND_W),
    .RESET_VALUE (PEND_RESET)
  ) u_pending (
    .clock   (clock),
    .rst     (rst),
    .swWrite (regWrite),
    .swData  (pendWrite),
    .hwSet   (pendSet),
    .hwClear (pendClear),
    .flags   (pendingVector)
  );

  // ----------------------------------------------------------------------
  // active bits
  // ----------------------------------------------------------------------

  logic [ACT_W-1:0] actWrite;
  logic [ACT_W-1:0] actSet;
  logic [ACT_W-1:0] actClear;

  assign actWrite[AI_TIMER]      = merged[TIMER_ACT_BIT];
  assign actWrite[AI_DEFERRED]   = merged[DEFERRED_ACT_BIT];
  assign actWrite[AI_DEBUG]      = merged[DEBUG_ACT_BIT];
  assign actWrite[AI_SUPERVISOR] = merged[SUPERVISOR_ACT_BIT];
  assign actWrite[AI_INSTR]      = merged[INSTR_FAULT_ACT_BIT];
  assign actWrite[AI_BUS]        = merged[BUS_FAULT_ACT_BIT];

  // entry wins over a return of the same exception in the same cycle
  assign actSet   = takeValid ? actMask(takeId) : '0;
  assign actClear = returnValid ? actMask(returnId) : '0;

  status_flags #(
    .W           (ACT_W),
    .RESET_VALUE (ACT_RESET)
  ) u_active (
    .clock   (clock),
    .rst     (rst),
    .swWrite (regWrite),
    .swData  (actWrite),
    .hwSet   (actSet),
    .hwClear (actClear),
    .flags   (activeVector)
  );

  // ----------------------------------------------------------------------
  // read back
  // ----------------------------------------------------------------------

  // reserved positions stay zero
  always_comb begin
    readValue                        = 32'h0000_0000;
    readValue[ACCESS_FAULT_EN_BIT]   = accessFaultEnable;
    readValue[SUPERVISOR_PEND_BIT]   = pendingVector[PI_SUPERVISOR];
    readValue[BUS_FAULT_PEND_BIT]    = pendingVector[PI_BUS];
    readValue[ACCESS_FAULT_PEND_BIT] = pendingVector[PI_ACCESS];
    readValue[INSTR_FAULT_PEND_BIT]  = pendingVector[PI_INSTR];
    readValue[TIMER_ACT_BIT]         = activeVector[AI_TIMER];
    readValue[DEFERRED_ACT_BIT]      = activeVector[AI_DEFERRED];
    readValue[DEBUG_ACT_BIT]         = activeVector[AI_DEBUG];
    readValue[SUPERVISOR_ACT_BIT]    = activeVector[AI_SUPERVISOR];
    readValue[INSTR_FAULT_ACT_BIT]   = activeVector[AI_INSTR];
    readValue[BUS_FAULT_ACT_BIT]     = activeVector[AI_BUS];
  end

endmodule

//--- system_handler_control_state_sva.sv
/*
  Checker for system_handler_control_state, bound to the design.
  Assumes zero-wait APB and single-cycle core event pulses.
*/
module system_handler_control_state_chk
  import shcs_pkg::*;
(
  // clock and reset
  input wire logic                  clock,
  input wire logic                  rst,
  // apb
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [APB_ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0]     pwdata,
  input wire logic [STRB_W-1:0]     pstrb,
  input wire logic [2:0]            pprot,
  input wire logic [DATA_W-1:0]     prdata,
  input wire logic                  pslverr,
  // core side
  input wire logic                  supervisorCallRequest,
  input wire logic                  busFaultRequest,
  input wire logic                  accessFaultRequest,
  input wire logic                  instructionFaultRequest,
  input wire logic                  busFaultEnable,
  input wire logic                  instructionFaultEnable,
  input wire logic                  takeValid,
  input wire exc_id_t               takeId,
  input wire logic                  returnValid,
  input wire exc_id_t               returnId,
  input wire logic                  accessFaultEnable,
  input wire logic [PEND_W-1:0]     pendingVector,
  input wire logic [ACT_W-1:0]      activeVector,
  input wire logic                  hardFaultRequest
);
  logic regWr;
  logic quiet;
  logic esc;
  assign regWr = psel && penable && pwrite && paddr == SHCS_OFFSET && pprot[0];
  assign quiet = !(takeValid || returnValid || supervisorCallRequest || busFaultRequest ||
                   accessFaultRequest || instructionFaultRequest);
  assign esc   = (busFaultRequest && !busFaultEnable) || (accessFaultRequest && !accessFaultEnable) ||
                 (instructionFaultRequest && !instructionFaultEnable);

  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  chk_bad_access_err: assert property (psel && penable && (paddr != SHCS_OFFSET || !pprot[0])
    |-> pslverr && prdata == 32'h0) else $error("refused access not flagged");
  chk_unpriv_keep: assert property (psel && penable && pwrite && !pprot[0] && quiet
    |=> $stable(pendingVector) && $stable(activeVector) && $stable(accessFaultEnable))
    else $error("unprivileged write changed state");
  chk_enable_write: assert property (regWr && pstrb[2]
    |=> accessFaultEnable == $past(pwdata[16])) else $error("enable bit not written");
  chk_pend_write: assert property (regWr && pstrb[1] && quiet
    |=> pendingVector == {$past(pwdata[12]), $past(pwdata[13]), $past(pwdata[14]), $past(pwdata[15])})
    else $error("pending bits not written");
  chk_act_write: assert property (regWr && pstrb[0] && pstrb[1] && quiet
    |=> activeVector == {$past(pwdata[1]), $past(pwdata[3]), $past(pwdata[7]), $past(pwdata[8]),
                         $past(pwdata[10]), $past(pwdata[11])}) else $error("active bits not written");
  chk_read_fields: assert property (psel && !penable && !pwrite && paddr == SHCS_OFFSET && pprot[0]
    |=> prdata == {15'h0, $past(accessFaultEnable), $past(pendingVector[0]), $past(pendingVector[1]),
                   $past(pendingVector[2]), $past(pendingVector[3]), $past(activeVector[0]),
                   $past(activeVector[1]), 1'b0, $past(activeVector[2]), $past(activeVector[3]), 3'h0,
                   $past(activeVector[4]), 1'b0, $past(activeVector[5]), 1'b0})
    else $error("read data layout wrong");
  chk_escalate: assert property (esc |=> hardFaultRequest) else $error("no escalation");
  chk_no_false_hf: assert property (!esc |=> !hardFaultRequest) else $error("spurious escalation");
  chk_take_bus: assert property (takeValid && takeId == EXC_BUS_FAULT && !busFaultRequest
    |=> !pendingVector[PI_BUS] && activeVector[AI_BUS]) else $error("take did not move bus fault");
  chk_return_timer: assert property (returnValid && returnId == EXC_TIMER &&
    !(takeValid && takeId == EXC_TIMER) |=> !activeVector[AI_TIMER]) else $error("return kept timer");

  cover property (takeValid && takeId == EXC_BUS_FAULT);
  cover property (hardFaultRequest);
  cover property (psel && penable && pslverr);
endmodule

bind system_handler_control_state system_handler_control_state_chk system_handler_control_state_chk_i (
  .clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pstrb(pstrb), .pprot(pprot), .prdata(prdata), .pslverr(pslverr),
  .supervisorCallRequest(supervisorCallRequest), .busFaultRequest(busFaultRequest),
  .accessFaultRequest(accessFaultRequest), .instructionFaultRequest(instructionFaultRequest),
  .busFaultEnable(busFaultEnable), .instructionFaultEnable(instructionFaultEnable),
  .takeValid(takeValid), .takeId(takeId), .returnValid(returnValid), .returnId(returnId),
  .accessFaultEnable(accessFaultEnable), .pendingVector(pendingVector),
  .activeVector(activeVector), .hardFaultRequest(hardFaultRequest));

//--- system_handler_control_state_tb.sv
/*
  Self-checking bench for system_handler_control_state.
  Assumes the checker is bound by its own file; drives all ports directly.
*/
module system_handler_control_state_tb
  import shcs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [3:0]  pstrb = '0, req = '0, pend;
  logic [2:0]  pprot = '0;
  logic [5:0]  act;
  logic        pready, pslverr, err, afEn, hfReq, busEn = 1, instrEn = 1, takeValid = 0, returnValid = 0;
  exc_id_t     takeId = EXC_OTHER, returnId = EXC_OTHER;
  int          numErrors = 0, nTests = 0, hfCount = 0;

  system_handler_control_state system_handler_control_state_i (
    .clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .pprot(pprot), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .supervisorCallRequest(req[0]), .busFaultRequest(req[1]),
    .accessFaultRequest(req[2]), .instructionFaultRequest(req[3]), .busFaultEnable(busEn),
    .instructionFaultEnable(instrEn), .takeValid(takeValid), .takeId(takeId),
    .returnValid(returnValid), .returnId(returnId), .accessFaultEnable(afEn),
    .pendingVector(pend), .activeVector(act), .hardFaultRequest(hfReq));

  initial forever #2 clock = ~clock;
  always @(posedge clock) if (hfReq === 1'b1) hfCount++;

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] exp, got);
    nTests++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      numErrors++;
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s, input logic [2:0] pr);
    int n;
    n = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    pprot   <= pr;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) check("pready", 32'h1, 32'h0);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask

  task automatic ev(input logic [3:0] r, input logic tk, rt, input exc_id_t id);
    req         <= r;
    takeValid   <= tk;
    returnValid <= rt;
    takeId      <= id;
    returnId    <= id;
    @(posedge clock);
    req         <= 4'h0;
    takeValid   <= 1'b0;
    returnValid <= 1'b0;
    @(posedge clock);
  endtask

  // expected core-side view of a register word
  function automatic logic [31:0] outs(input logic [31:0] w);
    return {21'h0, w[16], w[12], w[13], w[14], w[15], w[1], w[3], w[7], w[8], w[10], w[11]};
  endfunction

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_bits;
    logic [31:0] exp;
    apb(1'b0, 12'h000, 32'h0, 4'h0, 3'h1);
    check("reset word", 32'h0, rd);
    for (int i = 0; i < 32; i++) begin
      exp = (32'h1 << i) & 32'h0001_fd8a;
      apb(1'b1, 12'h000, 32'h1 << i, 4'hf, 3'h1);
      apb(1'b0, 12'h000, 32'h0, 4'h0, 3'h1);
      check("readback", exp, rd);
      check("read response", 32'h0, 32'(err));
      check("vectors", outs(exp), {21'h0, afEn, pend, act});
    end
  endtask

  task automatic t_lanes_refused;
    logic [31:0] saved;
    apb(1'b1, 12'h000, 32'h0, 4'hf, 3'h1);
    apb(1'b1, 12'h000, 32'hffff_ffff, 4'h2, 3'h1);
    apb(1'b1, 12'h000, 32'hffff_ffff, 4'h4, 3'h1);
    apb(1'b0, 12'h000, 32'h0, 4'h0, 3'h1);
    check("lane merge", 32'h0001_fd00, rd);
    apb(1'b1, 12'h000, 32'h0, 4'hf, 3'h0);
    check("unpriv err", 32'h1, 32'(err));
    apb(1'b0, 12'h000, 32'h0, 4'h0, 3'h0);
    check("unpriv read", 32'h0, rd);
    apb(1'b1, 12'h004, 32'h0, 4'hf, 3'h1);
    check("unmapped err", 32'h1, 32'(err));
    apb(1'b0, 12'h000, 32'h0, 4'h0, 3'h1);
    check("kept word", 32'h0001_fd00, rd);
    apb(1'b1, 12'h000, rd | 32'h0000_0008, 4'hf, 3'h1);
    apb(1'b0, 12'h000, 32'h0, 4'h0, 3'h1);
    check("rmw word", 32'h0001_fd08, rd);
    saved = rd;
    apb(1'b1, 12'h000, 32'h0, 4'hf, 3'h1);
    check("cleared vectors", 32'h0, {21'h0, afEn, pend, act});
    apb(1'b1, 12'h000, saved, 4'hf, 3'h1);
    check("restored vectors", outs(32'h0001_fd08), {21'h0, afEn, pend, act});
  endtask

  task automatic t_events;
    int pi[7] = '{0, 1, 2, 3, -1, -1, -1};
    int ai[7] = '{3, 5, -1, 4, 0, 1, 2};
    apb(1'b1, 12'h000, 32'h0001_0000, 4'hf, 3'h1);
    for (int i = 0; i < 7; i++) begin
      if (pi[i] >= 0) begin
        ev(4'h1 << pi[i], 1'b0, 1'b0, exc_id_t'(i));
        check("pending set", 32'h1 << pi[i], 32'(pend));
      end
      ev(4'h0, 1'b1, 1'b0, exc_id_t'(i));
      check("pending taken", 32'h0, 32'(pend));
      check("active taken", ai[i] >= 0 ? 32'h1 << ai[i] : 32'h0, 32'(act));
      ev(4'h0, 1'b0, 1'b1, exc_id_t'(i));
      check("active returned", 32'h0, 32'(act));
    end
    check("no escalation", 32'h0, 32'(hfCount));
  endtask

  task automatic t_escalate;
    apb(1'b1, 12'h000, 32'h0, 4'hf, 3'h1);
    busEn   <= 1'b0;
    instrEn <= 1'b0;
    for (int r = 1; r < 4; r++) begin
      ev(4'h1 << r, 1'b0, 1'b0, EXC_OTHER);
      check("disabled pending", 32'h0, 32'(pend));
    end
    @(posedge clock);
    check("hard faults", 32'h3, 32'(hfCount));
  endtask

  // reset in mid-run clears every field and output
  task automatic t_reset;
    apb(1'b1, 12'h000, 32'h0001_fd8a, 4'hf, 3'h1);
    check("before reset", outs(32'h0001_fd8a), {21'h0, afEn, pend, act});
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    check("reset vectors", 32'h0, {21'h0, afEn, pend, act});
    check("reset hard fault", 32'h0, 32'(hfReq));
    rst <= 1'b0;
    @(posedge clock);
    apb(1'b0, 12'h000, 32'h0, 4'h0, 3'h1);
    check("word after reset", 32'h0, rd);
  endtask

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", nTests, numErrors);
    if (numErrors == 0 && nTests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clock);
    numErrors++;
    end_of_test;
  end

  initial begin
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    t_bits;
    t_lanes_refused;
    t_events;
    t_escalate;
    t_reset;
    end_of_test;
  end
endmodule
